// file: hw/lber_consts.svh
// Register selects, field positions and reset values for the last branch recorder
`ifndef LBER_CONSTS_SVH
`define LBER_CONSTS_SVH
`define LBER_SEL_CTRL 3'h0
`define LBER_SEL_BR_SRC 3'h1
`define LBER_SEL_BR_TGT 3'h2
`define LBER_SEL_EX_SRC 3'h3
`define LBER_SEL_EX_TGT 3'h4
`define LBER_BIT_REC 0
`define LBER_BIT_STEP 1
`define LBER_BIT_PIN_LO 2
`define LBER_BIT_PIN_HI 5
`define LBER_BIT_MSG 6
`define LBER_CTRL_MASK 32'h0000007f
`define LBER_CTRL_RST 32'h00000000
`define LBER_IP_RST 32'h00000000
`endif

// file: hw/lber_pkg.sv
// Types shared by the last branch recorder
package lber_pkg;
  typedef struct packed {
    logic br_taken;
    logic intr;
    logic exc;
    logic dbg_fault;
    logic [31:0] src_ip;
    logic [31:0] tgt_ip;
  } lber_xfer_t;

  typedef enum logic [1:0] {
    LBER_IDLE = 2'b00,
    LBER_RDATA = 2'b01
  } lber_state_t;

  typedef struct packed {
    lber_state_t st;
    logic [31:0] ctrl;
    logic [31:0] br_src;
    logic [31:0] br_tgt;
    logic [31:0] ex_src;
    logic [31:0] ex_tgt;
    logic [31:0] rdata;
    logic rvalid;
    logic wack;
    logic [3:0] pin_n;
    logic msg_valid;
    logic [63:0] msg;
    logic [1:0] step_mode;
  } lber_state_s_t;
endpackage

// file: hw/lber_recorder.sv
// Last branch, interrupt and exception recorder with debug control register
// Functional notes
// - With record_enable set, the last branch and last interrupt or exception addresses are captured.
// - Taken branches, non-debug exceptions and serviced interrupts are all recorded while enabled.
// - A debug fault clears record_enable before its handler runs.
// - A debug fault leaves all four capture registers untouched.
// - A taken branch loads its own address as source and its target as target.
// - An interrupt or exception loads the interrupted address as source and the handler as target.
// - An interrupt or exception first copies the branch pair into the exception pair.
// - Each capture register is a 32-bit instruction pointer.
// - Captured values are code segment offsets, as supplied by the core.
// - All four capture registers are readable through the model register read port.
// - Control writes are taken only at privilege level 0 or in real-address mode.
// - With step_on_branch set, the trap flag steps on taken branches rather than instructions.
// - Each set pin-select bit makes its pin pulse low once per match of its address register.
// - With a pin-select bit clear the pin reports performance events, without touching execution.
// - With branch_msg_on set, branch trace messages are sent and capture contents are undefined.
`timescale 1ns/1ps
`default_nettype none
`include "lber_consts.svh"
module lber_recorder (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state while low, except that reset still loads
  input wire lber_pkg::lber_xfer_t xfer, // Control transfer reported by the core
  input wire logic trap_flag, // Trap flag from cpu_flag_word
  input wire logic [3:0] bkpt_match, // Match strobes of debug_addr_0..debug_addr_3
  input wire logic [3:0] perf_event, // Performance event strobes
  input wire logic model_reg_read, // Register read strobe
  input wire logic model_reg_write, // Register write strobe
  input wire logic [2:0] reg_sel, // Register select
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic [1:0] priv_level, // Current privilege level
  input wire logic real_mode, // Real-address mode
  output logic [31:0] reg_rdata, // Read data
  output logic reg_rvalid, // Read data valid pulse
  output logic reg_wack, // Write accepted pulse
  output logic [3:0] bkpt_pin_n, // bkpt_pin0_n..bkpt_pin3_n
  output logic step_after_branch, // Request single-step trap after a branch
  output logic step_each_insn, // Per-instruction stepping is active
  output logic msg_valid, // Branch trace message strobe
  output logic [63:0] msg_data // Branch trace message, target over source
);
  lber_pkg::lber_state_s_t s_r;
  lber_pkg::lber_state_s_t s_nxt;

  function automatic logic [31:0] read_mux(input lber_pkg::lber_state_s_t s, input logic [2:0] sel);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (sel)
      `LBER_SEL_CTRL: v = s.ctrl;
      `LBER_SEL_BR_SRC: v = s.br_src;
      `LBER_SEL_BR_TGT: v = s.br_tgt;
      `LBER_SEL_EX_SRC: v = s.ex_src;
      `LBER_SEL_EX_TGT: v = s.ex_tgt;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  logic rec_on;
  logic step_on;
  logic msg_on;
  logic [3:0] pin_sel;
  logic ex_event;
  logic wr_ok;

  always_comb begin
    rec_on = s_r.ctrl[`LBER_BIT_REC];
    step_on = s_r.ctrl[`LBER_BIT_STEP];
    msg_on = s_r.ctrl[`LBER_BIT_MSG];
    pin_sel = s_r.ctrl[`LBER_BIT_PIN_HI:`LBER_BIT_PIN_LO];
    // Debug faults are never counted as exceptions for recording
    ex_event = (xfer.intr | xfer.exc) & ~xfer.dbg_fault;
    wr_ok = model_reg_write & ((priv_level == 2'h0) | real_mode);

    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.wack = 1'b0;
    s_nxt.msg_valid = 1'b0;
    s_nxt.st = lber_pkg::LBER_IDLE;

    if (model_reg_read) begin
      s_nxt.rdata = read_mux(s_r, reg_sel);
      s_nxt.rvalid = 1'b1;
      s_nxt.st = lber_pkg::LBER_RDATA;
    end

    if (wr_ok && reg_sel == `LBER_SEL_CTRL) begin
      s_nxt.ctrl = reg_wdata & `LBER_CTRL_MASK;
      s_nxt.wack = 1'b1;
    end

    if (rec_on && !xfer.dbg_fault) begin
      if (ex_event) begin
        s_nxt.ex_src = s_r.br_src;
        s_nxt.ex_tgt = s_r.br_tgt;
        s_nxt.br_src = xfer.src_ip;
        s_nxt.br_tgt = xfer.tgt_ip;
      end else if (xfer.br_taken) begin
        s_nxt.br_src = xfer.src_ip;
        s_nxt.br_tgt = xfer.tgt_ip;
      end
    end

    if (msg_on && !xfer.dbg_fault && (xfer.br_taken || ex_event)) begin
      s_nxt.msg = {xfer.tgt_ip, xfer.src_ip};
      s_nxt.msg_valid = 1'b1;
    end

    // fault clears enable, winning over a write
    if (xfer.dbg_fault) begin
      s_nxt.ctrl[`LBER_BIT_REC] = 1'b0;
    end

    for (int i = 0; i < 4; i++) begin
      s_nxt.pin_n[i] = pin_sel[i] ? ~bkpt_match[i] : ~perf_event[i];
    end

    s_nxt.step_mode[0] = trap_flag & step_on & (xfer.br_taken | ex_event);
    s_nxt.step_mode[1] = trap_flag & ~step_on;

    if (!reset_n) begin
      s_nxt.st = lber_pkg::LBER_IDLE;
      s_nxt.ctrl = `LBER_CTRL_RST;
      s_nxt.br_src = `LBER_IP_RST;
      s_nxt.br_tgt = `LBER_IP_RST;
      s_nxt.ex_src = `LBER_IP_RST;
      s_nxt.ex_tgt = `LBER_IP_RST;
      s_nxt.rdata = 32'h00000000;
      s_nxt.rvalid = 1'b0;
      s_nxt.wack = 1'b0;
      s_nxt.pin_n = 4'hf;
      s_nxt.msg_valid = 1'b0;
      s_nxt.msg = 64'h0000000000000000;
      s_nxt.step_mode = 2'h0;
    end
  end

  // Reset overrides the clock enable so reset never depends on it
  always_ff @(posedge clk) begin
    if (clk_en || !reset_n) begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;
  assign reg_wack = s_r.wack;
  assign bkpt_pin_n = s_r.pin_n;
  assign step_after_branch = s_r.step_mode[0];
  assign step_each_insn = s_r.step_mode[1];
  assign msg_valid = s_r.msg_valid;
  assign msg_data = s_r.msg;
endmodule
`default_nettype wire

// file: tb/lber_core_model.sv
// Core stand-in that reports control transfers
`timescale 1ns/1ps
`default_nettype none
module lber_core_model (
  input wire logic clk, // Core clock
  output var lber_pkg::lber_xfer_t xfer // Transfer report
);
  initial xfer = '0;
  // offsets come straight from the core
  task automatic send(input logic [3:0] k, input logic [31:0] s, input logic [31:0] t);
    xfer <= {k, s, t};
    @(posedge clk);
    // Idle addresses flip so a stale pair never looks fresh
    xfer <= {4'h0, ~s, ~t};
  endtask
endmodule
`default_nettype wire

// file: tb/lber_checker.sv
// Recorder port assertions
`timescale 1ns/1ps
`default_nettype none
module lber_checker (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic clk_en, // Advance
  input wire lber_pkg::lber_xfer_t xfer, // Event
  input wire logic trap_flag, // Trap
  input wire logic [3:0] bkpt_match, // Match
  input wire logic [3:0] perf_event, // Perf
  input wire logic model_reg_read, // Read
  input wire logic model_reg_write, // Write
  input wire logic [2:0] reg_sel, // Select
  input wire logic [1:0] priv_level, // Level
  input wire logic real_mode, // Real
  input wire logic reg_rvalid, // Valid
  input wire logic reg_wack, // Ack
  input wire logic [3:0] bkpt_pin_n, // Pins
  input wire logic step_each_insn, // Step
  input wire logic msg_valid // Msg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (clk_en && model_reg_read |=> reg_rvalid) else $error("no rvalid");
  a_read_quiet: assert property (clk_en && !model_reg_read |=> !reg_rvalid) else $error("stray rvalid");
  a_write_refused: assert property (clk_en && model_reg_write && (|priv_level) && !real_mode |=> !reg_wack)
    else $error("bad wack");
  a_write_taken: assert property (clk_en && model_reg_write && reg_sel == 3'h0 && !((|priv_level) && !real_mode)
    |=> reg_wack) else $error("no wack");
  a_write_quiet: assert property (clk_en && !model_reg_write |=> !reg_wack) else $error("stray wack");
  a_pin_idle: assert property (clk_en && (bkpt_match | perf_event) == 4'h0 |=> bkpt_pin_n == 4'hf)
    else $error("stray pin");
  a_insn_step: assert property (clk_en && !trap_flag |=> !step_each_insn) else $error("stray step");
  a_msg_cause: assert property (clk_en && !(xfer.br_taken || xfer.intr || xfer.exc) |=> !msg_valid)
    else $error("stray msg");
endmodule
bind lber_recorder lber_checker u_chk (.*);
`default_nettype wire

// file: tb/lber_recorder_tb_top.sv
// Testbench for the last branch recorder
`timescale 1ns/1ps
`default_nettype none
module lber_recorder_tb_top;
  typedef struct packed {logic [3:0] k; logic [7:0] s, t; logic [2:0] sel; logic [7:0] e;} lber_row_t;
  logic clk = 0, reset_n = 0, model_reg_read = 0, model_reg_write = 0, trap_flag = 0, real_mode = 0, clk_en = 1;
  logic [3:0] bkpt_match = 4'h0, perf_event = 4'h0, bkpt_pin_n;
  logic [2:0] reg_sel = 3'h0;
  logic [1:0] priv_level = 2'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_rvalid, reg_wack, step_after_branch, step_each_insn, msg_valid;
  logic [63:0] msg_data;
  lber_pkg::lber_xfer_t xfer;
  int num_errors = 0, compares = 0;
  // Kind is branch, interrupt, exception, debug fault from the top bit down
  lber_row_t rows [7] = '{'{4'h8, 8'h11, 8'h22, 3'h1, 8'h11}, '{4'h8, 8'h33, 8'h44, 3'h2, 8'h44},
    '{4'h2, 8'h55, 8'h66, 3'h3, 8'h33}, '{4'h4, 8'h77, 8'h88, 3'h4, 8'h66}, '{4'h1, 8'h99, 8'haa, 3'h1, 8'h77},
    '{4'h0, 8'h00, 8'h00, 3'h0, 8'h00}, '{4'h8, 8'hbb, 8'hcc, 3'h2, 8'h88}};
  always #25 clk = ~clk;
  lber_core_model core (.clk, .xfer);
  lber_recorder DUT (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .xfer(xfer),
    .trap_flag(trap_flag),
    .bkpt_match(bkpt_match),
    .perf_event(perf_event),
    .model_reg_read(model_reg_read),
    .model_reg_write(model_reg_write),
    .reg_sel(reg_sel),
    .reg_wdata(reg_wdata),
    .priv_level(priv_level),
    .real_mode(real_mode),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .reg_wack(reg_wack),
    .bkpt_pin_n(bkpt_pin_n),
    .step_after_branch(step_after_branch),
    .step_each_insn(step_each_insn),
    .msg_valid(msg_valid),
    .msg_data(msg_data)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [2:0] s, input logic [31:0] exp);
    @(posedge clk);
    model_reg_read <= 1'b1;
    reg_sel <= s;
    @(posedge clk);
    model_reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wr(input logic [31:0] d, input logic [1:0] pl, input logic rm);
    @(posedge clk);
    model_reg_write <= 1'b1;
    reg_sel <= 3'h0;
    reg_wdata <= d;
    priv_level <= pl;
    real_mode <= rm;
    @(posedge clk);
    model_reg_write <= 1'b0;
  endtask
  task automatic end_sim;
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wr(32'h1, 2'h0, 1'b0);
    foreach (rows[i]) begin
      @(posedge clk);
      core.send(rows[i].k, {24'h0, rows[i].s}, {24'h0, rows[i].t});
      rd(rows[i].sel, {24'h0, rows[i].e});
    end
    // recording turned back on, upper bits dropped
    wr(32'hffffffff, 2'h0, 1'b0);
    wr(32'h0, 2'h3, 1'b0);
    rd(3'h0, 32'h7f);
    @(posedge clk);
    bkpt_match <= 4'h1;
    @(posedge clk);
    bkpt_match <= 4'h0;
    #1 chk({28'h0, bkpt_pin_n}, 32'he);
    @(posedge clk);
    #1 chk({28'h0, bkpt_pin_n}, 32'hf);
    @(posedge clk);
    trap_flag <= 1'b1;
    core.send(4'h8, 32'h1234, 32'h5678);
    #1 chk({29'h0, msg_valid, step_after_branch, step_each_insn}, 32'h6);
    chk(msg_data[63:32], 32'h5678);
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    rd(3'h0, 32'h0);
    #1 chk({31'h0, step_each_insn}, 32'h1);
    wr(32'h2, 2'h3, 1'b1);
    rd(3'h0, 32'h2);
    @(posedge clk);
    perf_event <= 4'h2;
    @(posedge clk);
    perf_event <= 4'h0;
    #1 chk({28'h0, bkpt_pin_n}, 32'hd);
    // Frozen clock enable must swallow a perf event
    @(posedge clk);
    clk_en <= 1'b0;
    perf_event <= 4'h1;
    @(posedge clk);
    perf_event <= 4'h0;
    clk_en <= 1'b1;
    #1 chk({28'h0, bkpt_pin_n}, 32'hf);
    end_sim;
  end
  // About six times the expected run
  initial begin
    #20us;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
